// File: shared/srpc_pkg.sv
// shared constants and types for the system reset and power control block
package srpc_pkg;

  // register byte offsets on the core i/o space
  localparam logic [7:0] SRPC_OFS_CAUSE = 8'h54;
  localparam logic [7:0] SRPC_OFS_VCTRL = 8'h55;
  localparam logic [7:0] SRPC_OFS_GATE = 8'h64;

  // register reset values
  localparam logic [7:0] SRPC_RST_CAUSE = 8'h00;
  localparam logic [7:0] SRPC_RST_VCTRL = 8'h00;
  localparam logic [7:0] SRPC_RST_GATE = 8'h00;
  localparam logic [7:0] SRPC_RD_ZERO = 8'h00;

  // vector control field positions
  localparam int SRPC_VC_UNLOCK_BIT = 0;
  localparam int SRPC_VC_SELECT_BIT = 1;

  // reset cause field positions
  localparam int SRPC_CAUSE_POR_BIT = 0;
  localparam int SRPC_CAUSE_PIN_BIT = 1;
  localparam int SRPC_CAUSE_BOD_BIT = 2;
  localparam int SRPC_CAUSE_WDT_BIT = 3;
  localparam int SRPC_CAUSE_W = 4;

  // peripheral clock gate field positions
  localparam int SRPC_GATE_CONVERTER = 0;
  localparam int SRPC_GATE_SERIAL_0 = 1;
  localparam int SRPC_GATE_SPI_0 = 2;
  localparam int SRPC_GATE_TIMER_1 = 3;
  localparam int SRPC_GATE_SERIAL_1 = 4;
  localparam int SRPC_GATE_TIMER_0 = 5;
  localparam int SRPC_GATE_TIMER_2 = 6;
  localparam int SRPC_GATE_TWO_WIRE_0 = 7;
  localparam int SRPC_GATE_W = 8;

  // vector change unlock window in core clock cycles
  localparam logic [2:0] SRPC_UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] SRPC_UNLOCK_LAST = 3'h1;

  // reset stretch counter and fuse index widths
  localparam int SRPC_DLY_W = 16;
  localparam int SRPC_SUT_W = 2;
  localparam int SRPC_CLOCK_SELECT_FUSES_W = 4;
  localparam int SRPC_FUSE_W = SRPC_SUT_W + SRPC_CLOCK_SELECT_FUSES_W;
  localparam int SRPC_FUSE_N = 1 << SRPC_FUSE_W;
  localparam logic [SRPC_DLY_W-1:0] SRPC_DLY_DEFAULT = 16'h0400;

  // vector change sequence states, gray along idle-open-trail
  typedef enum logic [1:0] {
    SRPC_VC_IDLE = 2'b00,
    SRPC_VC_OPEN = 2'b01,
    SRPC_VC_TRAIL = 2'b11
  } srpc_vc_state_t;

  // synchronised reset sources
  typedef struct packed {
    logic wdt_tog;
    logic bod_low;
    logic pin_n;
    logic por;
  } srpc_src_t;

  // synchronised fuse settings
  typedef struct packed {
    logic pin_dis;
    logic bod_en;
    logic wdt_mode;
    logic [SRPC_SUT_W-1:0] startup_time_fuses;
    logic [SRPC_CLOCK_SELECT_FUSES_W-1:0] clock_select_fuses;
  } srpc_fuse_t;

endpackage

// File: logic/srpc_sync.sv
// two-stage synchroniser for pin and cross-domain inputs
`timescale 1ns/1ps
module srpc_sync
  import srpc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second; reset to each input's idle level
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// File: logic/srpc_stretch.sv
// reset stretch counter with asynchronous assertion of the system reset
`timescale 1ns/1ps
module srpc_stretch
  import srpc_pkg::*;
#(
  parameter int CW = SRPC_DLY_W
)
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic async_src_in,
  input wire logic hold_in,
  input wire logic [CW-1:0] load_val_in,
  output logic sys_reset_out,
  output logic release_out
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic reset_nxt;
  logic cnt_live;

  // counter reloads while any source holds, then runs down
  assign cnt_live = (cnt_r > CW'(1));
  assign cnt_nxt = hold_in ? load_val_in :
                   (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;
  assign reset_nxt = hold_in | cnt_live;

  // counter state
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  // set with no clock so ports fall back at once on a source
  always_ff @(posedge mclk_in or posedge async_src_in)
  begin
    if (async_src_in)
    begin
      sys_reset_out <= 1'b1;
      release_out <= 1'b0;
    end
    else
    begin
      sys_reset_out <= reset_nxt;
      release_out <= sys_reset_out & ~reset_nxt;
    end
  end

endmodule

// File: logic/srpc_top.sv
// system reset, vector relocation guard and peripheral clock gating
`timescale 1ns/1ps
module srpc_top
  import srpc_pkg::*;
#(
  parameter logic [SRPC_DLY_W-1:0] DLY_TABLE [SRPC_FUSE_N] =
    '{default: SRPC_DLY_DEFAULT}
)
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic reset_pin_n_in,
  input wire logic wdt_timeout_tog_in,
  input wire logic brownout_low_in,
  input wire logic wdt_reset_mode_in,
  input wire logic brownout_enable_in,
  input wire logic pin_reset_disable_fuse_in,
  input wire logic [SRPC_SUT_W-1:0] startup_time_fuses_in,
  input wire logic [SRPC_CLOCK_SELECT_FUSES_W-1:0] clock_select_fuses_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic insn_done_in,
  input wire logic exec_in_boot_in,
  input wire logic app_section_lock_bit_in,
  input wire logic boot_section_lock_bit_in,
  input wire logic timer2_async_clock_select_in,
  output logic [7:0] io_rdata_out,
  output logic sys_reset_out,
  output logic core_start_out,
  output logic irq_block_out,
  output logic vector_base_select_out,
  output logic [SRPC_GATE_W-1:0] periph_clk_en_out,
  output logic comparator_mux_deny_out
);

  // address match, shared by the read and write decoders
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  srpc_src_t src_s;
  srpc_fuse_t fuse_s;
  logic pin_src_raw;
  logic bod_src_raw;
  logic async_src;
  logic wdt_tog_d_r;
  logic wdt_pulse_r;
  logic wdt_edge;
  logic pin_src_s;
  logic bod_src_s;
  logic hold;
  logic [SRPC_FUSE_W-1:0] fuse_idx;
  logic [SRPC_DLY_W-1:0] dly_load;
  logic stretch_reset;
  logic stretch_release;
  logic regs_reset;

  // pin only counts when its disable fuse is clear
  assign pin_src_raw = ~reset_pin_n_in & ~pin_reset_disable_fuse_in;
  // brown-out counts only when the detector is enabled
  assign bod_src_raw = brownout_low_in & brownout_enable_in;
  // raw sources assert reset with no clock edge
  assign async_src = por_in | pin_src_raw | bod_src_raw;

  // source and fuse pins cross in first; pin idles high, else reset looks like a pin low
  localparam srpc_src_t SRC_IDLE = '{1'b0, 1'b0, 1'b1, 1'b0};
  srpc_sync #(
    .W($bits(srpc_src_t) + $bits(srpc_fuse_t)),
    .RST_VAL({SRC_IDLE, srpc_fuse_t'('0)})
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in({wdt_timeout_tog_in, brownout_low_in, reset_pin_n_in,
               por_in, pin_reset_disable_fuse_in, brownout_enable_in,
               wdt_reset_mode_in, startup_time_fuses_in,
               clock_select_fuses_in}),
    .sync_out({src_s, fuse_s})
  );

  // watchdog time-out arrives as a toggle from its own oscillator
  assign wdt_edge = (src_s.wdt_tog ^ wdt_tog_d_r) & fuse_s.wdt_mode;
  assign pin_src_s = ~src_s.pin_n & ~fuse_s.pin_dis;
  assign bod_src_s = src_s.bod_low & fuse_s.bod_en;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      wdt_tog_d_r <= 1'b0;
      wdt_pulse_r <= 1'b0;
    end
    else
    begin
      wdt_tog_d_r <= src_s.wdt_tog;
      wdt_pulse_r <= wdt_edge;
    end
  end

  // all four sources combined into the stretch hold
  assign hold = src_s.por | pin_src_s | bod_src_s | wdt_pulse_r;

  // stretch length looked up from the fuse-indexed parameter
  assign fuse_idx = {fuse_s.startup_time_fuses, fuse_s.clock_select_fuses};
  // count chosen by start-up time and clock select fuses
  assign dly_load = DLY_TABLE[fuse_idx];

  // assertion is immediate for por, pin and brown-out, only release is counted
  srpc_stretch #(
    .CW(SRPC_DLY_W)
  ) u_stretch (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_src_in(async_src),
    .hold_in(hold),
    .load_val_in(dly_load),
    .sys_reset_out(stretch_reset),
    .release_out(stretch_release)
  );

  // pin low resets at once; count runs once it rises
  assign sys_reset_out = stretch_reset;
  // core fetches the reset vector on this release pulse
  assign core_start_out = stretch_release;
  // internal reset returns the vector guard and clock gate registers to their initial values; cause flags are kept
  assign regs_reset = reset_in | stretch_reset;

  // register bus decode
  logic wr_cause;
  logic wr_vctrl;
  logic wr_gate;
  logic rd_cause;
  logic rd_vctrl;
  logic rd_gate;

  assign wr_cause = io_wr_in & reg_hit(io_addr_in, SRPC_OFS_CAUSE);
  assign wr_vctrl = io_wr_in & reg_hit(io_addr_in, SRPC_OFS_VCTRL);
  assign wr_gate = io_wr_in & reg_hit(io_addr_in, SRPC_OFS_GATE);
  assign rd_cause = io_rd_in & reg_hit(io_addr_in, SRPC_OFS_CAUSE);
  assign rd_vctrl = io_rd_in & reg_hit(io_addr_in, SRPC_OFS_VCTRL);
  assign rd_gate = io_rd_in & reg_hit(io_addr_in, SRPC_OFS_GATE);

  // reset cause flags; they must outlive the reset they record
  logic [SRPC_CAUSE_W-1:0] cause_r;
  logic [SRPC_CAUSE_W-1:0] cause_set;
  logic [SRPC_CAUSE_W-1:0] cause_clr;
  logic [SRPC_CAUSE_W-1:0] cause_nxt;

  assign cause_set[SRPC_CAUSE_POR_BIT] = src_s.por;
  assign cause_set[SRPC_CAUSE_PIN_BIT] = pin_src_s;
  assign cause_set[SRPC_CAUSE_BOD_BIT] = bod_src_s;
  assign cause_set[SRPC_CAUSE_WDT_BIT] = wdt_pulse_r;
  assign cause_clr = wr_cause ? ~io_wdata_in[SRPC_CAUSE_W-1:0] : '0;

  // set wins over a zero write; power-on wipes the other flags
  assign cause_nxt = src_s.por ?
    (SRPC_CAUSE_W'(1) << SRPC_CAUSE_POR_BIT) :
    ((cause_r & ~cause_clr) | cause_set);

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      cause_r <= SRPC_RST_CAUSE[SRPC_CAUSE_W-1:0];
    else
      cause_r <= cause_nxt;
  end

  // vector relocation sequence
  srpc_vc_state_t vc_state_r;
  srpc_vc_state_t vc_state_nxt;
  logic [2:0] vc_cnt_r;
  logic [2:0] vc_cnt_nxt;
  logic select_r;
  logic select_nxt;
  logic unlock_wr;
  logic select_wr;

  // a select write only counts inside the open window
  assign unlock_wr = wr_vctrl & io_wdata_in[SRPC_VC_UNLOCK_BIT];
  assign select_wr = wr_vctrl & ~io_wdata_in[SRPC_VC_UNLOCK_BIT] &
                     (vc_state_r == SRPC_VC_OPEN);
  assign select_nxt = select_wr ? io_wdata_in[SRPC_VC_SELECT_BIT] : select_r;

  // unlock opens a four-cycle window for the select write
  always_comb
  begin
    vc_state_nxt = vc_state_r;
    vc_cnt_nxt = vc_cnt_r;
    unique case (vc_state_r)
      SRPC_VC_IDLE:
      begin
        if (unlock_wr)
        begin
          vc_state_nxt = SRPC_VC_OPEN;
          vc_cnt_nxt = SRPC_UNLOCK_CYCLES;
        end
      end
      SRPC_VC_OPEN:
      begin
        // select write closes the window early
        if (unlock_wr)
          vc_cnt_nxt = SRPC_UNLOCK_CYCLES;
        else if (select_wr)
          vc_state_nxt = SRPC_VC_TRAIL;
        // window expires after exactly four cycles
        else if (vc_cnt_r == SRPC_UNLOCK_LAST)
          vc_state_nxt = SRPC_VC_IDLE;
        else
          vc_cnt_nxt = vc_cnt_r - 3'h1;
      end
      SRPC_VC_TRAIL:
      begin
        // mask lasts until the following instruction retires
        if (unlock_wr)
        begin
          vc_state_nxt = SRPC_VC_OPEN;
          vc_cnt_nxt = SRPC_UNLOCK_CYCLES;
        end
        else if (insn_done_in)
          vc_state_nxt = SRPC_VC_IDLE;
      end
      default:
        vc_state_nxt = SRPC_VC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (regs_reset)
    begin
      vc_state_r <= SRPC_VC_IDLE;
      vc_cnt_r <= '0;
      select_r <= SRPC_RST_VCTRL[SRPC_VC_SELECT_BIT];
    end
    else
    begin
      vc_state_r <= vc_state_nxt;
      vc_cnt_r <= vc_cnt_nxt;
      select_r <= select_nxt;
    end
  end

  // interrupt blocking
  logic lock_block;
  logic irq_block_nxt;

  // lock bits keep interrupts out of the other section
  assign lock_block = select_nxt ?
    (app_section_lock_bit_in & ~exec_in_boot_in) :
    (boot_section_lock_bit_in & exec_in_boot_in);
  // separate mask line; the core status flag stays untouched
  assign irq_block_nxt = (vc_state_nxt != SRPC_VC_IDLE) | lock_block;

  always_ff @(posedge mclk_in)
  begin
    if (regs_reset)
    begin
      irq_block_out <= 1'b0;
      vector_base_select_out <= SRPC_RST_VCTRL[SRPC_VC_SELECT_BIT];
    end
    else
    begin
      irq_block_out <= irq_block_nxt;
      vector_base_select_out <= select_nxt;
    end
  end

  // peripheral clock gate register
  logic [SRPC_GATE_W-1:0] gate_r;
  logic [SRPC_GATE_W-1:0] gate_nxt;
  logic [SRPC_GATE_W-1:0] gate_eff;

  assign gate_nxt = wr_gate ? io_wdata_in : gate_r;

  // timer 2 gate ignored while it runs from its own crystal
  assign gate_eff = gate_nxt &
    ~(SRPC_GATE_W'(timer2_async_clock_select_in) << SRPC_GATE_TIMER_2);

  // one clock enable per gate bit
  // clock stop only; timers keep their state and resume
  always_ff @(posedge mclk_in)
  begin
    if (regs_reset)
    begin
      gate_r <= SRPC_RST_GATE;
      periph_clk_en_out <= ~SRPC_RST_GATE;
      comparator_mux_deny_out <= SRPC_RST_GATE[SRPC_GATE_CONVERTER];
    end
    else
    begin
      gate_r <= gate_nxt;
      periph_clk_en_out <= ~gate_eff;
      // gated converter withholds its input multiplexer
      comparator_mux_deny_out <= gate_nxt[SRPC_GATE_CONVERTER];
    end
  end

  // read data, registered; unmapped addresses read zero
  logic [7:0] rdata_nxt;
  logic vc_unlocked;

  assign vc_unlocked = (vc_state_r == SRPC_VC_OPEN);
  assign rdata_nxt =
    rd_cause ? {{(8 - SRPC_CAUSE_W){1'b0}}, cause_r} :
    rd_vctrl ? {6'h00, select_r, vc_unlocked} :
    rd_gate ? gate_r : SRPC_RD_ZERO;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      io_rdata_out <= SRPC_RD_ZERO;
    else
      io_rdata_out <= rdata_nxt;
  end

endmodule

// File: verification/srpc_chk.sv
// concurrent checks on the reset, vector guard and clock gate ports
`timescale 1ns/1ps
module srpc_chk
  import srpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic reset_pin_n_in,
  input wire logic wdt_timeout_tog_in,
  input wire logic brownout_low_in,
  input wire logic wdt_reset_mode_in,
  input wire logic brownout_enable_in,
  input wire logic pin_reset_disable_fuse_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic exec_in_boot_in,
  input wire logic app_section_lock_bit_in,
  input wire logic boot_section_lock_bit_in,
  input wire logic timer2_async_clock_select_in,
  input wire logic sys_reset_out,
  input wire logic core_start_out,
  input wire logic irq_block_out,
  input wire logic vector_base_select_out,
  input wire logic [SRPC_GATE_W-1:0] periph_clk_en_out,
  input wire logic comparator_mux_deny_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // decoded accepted writes and combined reset request
  wire gate_wr = io_wr_in && io_addr_in == SRPC_OFS_GATE && !sys_reset_out;
  wire vc_wr = io_wr_in && io_addr_in == SRPC_OFS_VCTRL && !sys_reset_out;
  wire no_lock = !app_section_lock_bit_in && !boot_section_lock_bit_in;
  wire any_src = por_in || (!reset_pin_n_in && !pin_reset_disable_fuse_in)
    || (brownout_low_in && brownout_enable_in);

  // the two steps of a vector move
  sequence s_unlock;
    vc_wr && io_wdata_in[SRPC_VC_UNLOCK_BIT];
  endsequence
  sequence s_select;
    vc_wr && !io_wdata_in[SRPC_VC_UNLOCK_BIT];
  endsequence

  AST_GATE_BITS: assert property (gate_wr |=> sys_reset_out ||
    (periph_clk_en_out | 8'h40) == (~$past(io_wdata_in) | 8'h40))
    else $error("clock enables differ from gate write");
  AST_T2_ASYNC: assert property (timer2_async_clock_select_in |=>
    sys_reset_out || periph_clk_en_out[SRPC_GATE_TIMER_2])
    else $error("timer 2 gated while asynchronous");
  AST_MUX_DENY: assert property (gate_wr |=> sys_reset_out ||
    comparator_mux_deny_out == $past(io_wdata_in[SRPC_GATE_CONVERTER]))
    else $error("comparator deny differs from converter gate");
  AST_MASK_NOW: assert property (s_unlock |=> irq_block_out)
    else $error("unlock write did not mask");
  AST_MASK_FOUR: assert property (s_unlock ##1
    (!vc_wr && no_lock && !sys_reset_out)[*4] |=> !irq_block_out)
    else $error("mask not released after four cycles");
  AST_SEL_MOVE: assert property (s_unlock ##1 !vc_wr ##1 s_select |=>
    irq_block_out && vector_base_select_out == $past(io_wdata_in[1]))
    else $error("select write inside window not taken");
  AST_SEL_LOCKED: assert property ((s_select and !irq_block_out) |=>
    sys_reset_out || $stable(vector_base_select_out))
    else $error("select changed without unlock");
  AST_APP_LOCK: assert property (app_section_lock_bit_in &&
    vector_base_select_out && !exec_in_boot_in |=> sys_reset_out ||
    irq_block_out)
    else $error("app lock did not block");
  AST_SRC_NOW: assert property (any_src |-> sys_reset_out)
    else $error("active source without reset");
  AST_WDT_RESET: assert property (wdt_reset_mode_in &&
    $changed(wdt_timeout_tog_in) |-> ##[1:6] sys_reset_out)
    else $error("watchdog expiry gave no reset");
  AST_STRETCH: assert property ($fell(any_src) |-> sys_reset_out[*8])
    else $error("reset released before the stretch count");
  AST_START: assert property ($fell(sys_reset_out) |->
    ##[0:1] core_start_out)
    else $error("no start pulse after reset release");
endmodule

bind srpc_top srpc_chk i_srpc_chk (.*);

// File: verification/srpc_det_model.sv
// behavioural reset detectors on the far side of the block
`timescale 1ns/1ps
module srpc_det_model
(
  input wire logic mclk_in,
  output logic por_out,
  output logic pin_n_out,
  output logic bod_low_out,
  output logic wdt_tog_out
);
  // all detectors quiet at power-up of the bench
  initial
  begin
    por_out = 1'b0;
    pin_n_out = 1'b1;
    bod_low_out = 1'b0;
    wdt_tog_out = 1'b0;
  end

  // raise one source; the toggle is one event per expiry
  task automatic src_set(input int sel);
    @(posedge mclk_in);
    case (sel)
      0: por_out <= 1'b1;
      1: pin_n_out <= 1'b0;
      2: bod_low_out <= 1'b1;
      default: wdt_tog_out <= !wdt_tog_out;
    endcase
  endtask

  // level sources drop together, pin long past any filter
  task automatic src_clear();
    @(posedge mclk_in);
    por_out <= 1'b0;
    pin_n_out <= 1'b1;
    bod_low_out <= 1'b0;
  endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the reset, vector guard and clock gate block
`timescale 1ns/1ps
module tb
  import srpc_pkg::*;
;
  logic mclk_in = 1'b0, reset_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0;
  logic insn_done_in = 1'b0, exec_in_boot_in = 1'b0;
  logic wdt_reset_mode_in = 1'b0, brownout_enable_in = 1'b0;
  logic app_section_lock_bit_in = 1'b0, boot_section_lock_bit_in = 1'b0;
  logic timer2_async_clock_select_in = 1'b0, pin_reset_disable_fuse_in = 1'b0;
  logic [SRPC_SUT_W-1:0] startup_time_fuses_in = 2'h0;
  logic [SRPC_CLOCK_SELECT_FUSES_W-1:0] clock_select_fuses_in = 4'h0;
  logic [7:0] io_addr_in = 8'h00, io_wdata_in = 8'h00, io_rdata_out;
  logic por_in, reset_pin_n_in, wdt_timeout_tog_in, brownout_low_in;
  logic sys_reset_out, core_start_out, irq_block_out, vector_base_select_out;
  logic comparator_mux_deny_out;
  logic [SRPC_GATE_W-1:0] periph_clk_en_out;
  int fail_count = 0, n_compared = 0;

  // 50 MHz core clock
  always #10 mclk_in = ~mclk_in;

  // short stretch count keeps the run brief
  localparam int DLY = 8;
  srpc_top #(.DLY_TABLE('{default: 16'(DLY)})) i_srpc_top (.*);
  srpc_det_model i_srpc_det_model (
    .mclk_in(mclk_in),
    .por_out(por_in),
    .pin_n_out(reset_pin_n_in),
    .bod_low_out(brownout_low_in),
    .wdt_tog_out(wdt_timeout_tog_in)
  );

  // shared compare, bus cycles and waits
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge mclk_in);
    io_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge mclk_in);
    io_rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, io_rdata_out);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic edge_set(input int k, input logic v);
    @(posedge mclk_in);
    case (k)
      0: app_section_lock_bit_in <= v;
      1: boot_section_lock_bit_in <= v;
      2: exec_in_boot_in <= v;
      3: insn_done_in <= v;
      default: timer2_async_clock_select_in <= v;
    endcase
  endtask

  task automatic t_regs();
    for (int n = 0; n < 50 && sys_reset_out !== 1'b0; n++)
      @(posedge mclk_in);
    rd(SRPC_OFS_GATE, SRPC_RST_GATE);
    rd(SRPC_OFS_VCTRL, SRPC_RST_VCTRL);
    rd(SRPC_OFS_CAUSE, SRPC_RST_CAUSE);
    chk("clk en", 8'hFF, periph_clk_en_out);
    wr(8'h70, 8'h5A);
    rd(8'h70, SRPC_RD_ZERO);
    rd(SRPC_OFS_GATE, SRPC_RST_GATE);
    $display("test regs done");
  endtask

  task automatic t_gate();
    wr(SRPC_OFS_GATE, 8'h41);
    #1;
    chk("clk en", 8'hBE, periph_clk_en_out);
    chk("mux deny", 8'h01, {7'h0, comparator_mux_deny_out});
    edge_set(4, 1'b1);
    cyc(1);
    chk("t2 async", 8'hFE, periph_clk_en_out);
    edge_set(4, 1'b0);
    wr(SRPC_OFS_GATE, 8'hA5);
    rd(SRPC_OFS_GATE, 8'hA5);
    chk("clk en", 8'h5A, periph_clk_en_out);
    wr(SRPC_OFS_GATE, 8'h00);
    #1;
    chk("clk en", 8'hFF, periph_clk_en_out);
    chk("mux deny", 8'h00, {7'h0, comparator_mux_deny_out});
    $display("test gate done");
  endtask

  task automatic t_unlock_wait();
    wr(SRPC_OFS_VCTRL, 8'h02);
    #1;
    chk("sel locked", 8'h00, {7'h0, vector_base_select_out});
    wr(SRPC_OFS_VCTRL, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      #1;
      chk("mask", 8'h01, {7'h0, irq_block_out});
      @(posedge mclk_in);
    end
    #1;
    chk("mask off", 8'h00, {7'h0, irq_block_out});
    rd(SRPC_OFS_VCTRL, 8'h00);
    $display("test unlock wait done");
  endtask

  // unlock then select two cycles on; mask waits for a retire
  task automatic move(input logic [7:0] d, input logic m);
    wr(SRPC_OFS_VCTRL, 8'h01);
    wr(SRPC_OFS_VCTRL, d);
    cyc(3);
    chk("mask hold", 8'h01, {7'h0, irq_block_out});
    edge_set(3, 1'b1);
    edge_set(3, 1'b0);
    cyc(2);
    chk("mask end", {7'h0, m}, {7'h0, irq_block_out});
  endtask

  task automatic t_select();
    move(8'h02, 1'b0);
    chk("sel", 8'h01, {7'h0, vector_base_select_out});
    rd(SRPC_OFS_VCTRL, 8'h02);
    $display("test select done");
  endtask

  task automatic t_locks();
    edge_set(0, 1'b1);
    cyc(2);
    chk("app lock", 8'h01, {7'h0, irq_block_out});
    edge_set(2, 1'b1);
    cyc(2);
    chk("app lock boot", 8'h00, {7'h0, irq_block_out});
    edge_set(0, 1'b0);
    edge_set(1, 1'b1);
    move(8'h00, 1'b1);
    chk("sel", 8'h00, {7'h0, vector_base_select_out});
    edge_set(2, 1'b0);
    cyc(2);
    chk("boot lock app", 8'h00, {7'h0, irq_block_out});
    edge_set(1, 1'b0);
    $display("test locks done");
  endtask

  // each gated source with its enable off, then all four on; cause flags accumulate until power-on
  task automatic t_sources();
    int sel [7] = '{2, 1, 3, 3, 1, 2, 0};
    logic hit [7] = '{0, 0, 0, 1, 1, 1, 1};
    logic [7:0] cz [7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0A, 8'h0E, 8'h01};
    int n;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk_in);
      brownout_enable_in <= hit[i];
      pin_reset_disable_fuse_in <= !hit[i];
      wdt_reset_mode_in <= hit[i];
      wr(SRPC_OFS_GATE, 8'hA5);
      i_srpc_det_model.src_set(sel[i]);
      for (n = 0; n < 8 && sys_reset_out !== 1'b1; n++)
        cyc(1);
      i_srpc_det_model.src_clear();
      chk("reset", {7'h0, hit[i]}, {7'h0, sys_reset_out});
      for (n = 0; n < 40 && sys_reset_out === 1'b1; n++)
        cyc(1);
      // level sources add two synchroniser edges after the clear;
      // the watchdog pulse already ended one edge before it
      if (hit[i])
        chk("stretch", 8'(sel[i] == 3 ? DLY - 1 : DLY + 2), 8'(n));
      rd(SRPC_OFS_GATE, hit[i] ? 8'h00 : 8'hA5);
      rd(SRPC_OFS_CAUSE, cz[i]);
    end
    wr(SRPC_OFS_CAUSE, 8'h00);
    rd(SRPC_OFS_CAUSE, 8'h00);
    $display("test sources done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    fail_count++;
    final_report();
  end

  // reset, then the scenarios in order
  initial
  begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_regs();
    t_gate();
    t_unlock_wait();
    t_select();
    t_locks();
    t_sources();
    final_report();
  end
endmodule
